// [hdl/eesl_pkg.sv]
// Shared constants and carrier types for the encoder event and status logic.
// Assumes a 10 MHz system clock and an SPI drive link on a clock of its own.
package eesl_pkg;

  localparam int CLK_HZ = 10_000_000;

  // Longest times allowed for event latching and live-status refresh
  localparam int EVT_UPDATE_US  = 200;
  localparam int LIVE_UPDATE_US = 216;
  localparam int EVT_UPDATE_CYC  = (EVT_UPDATE_US * (CLK_HZ / 1_000_000));
  localparam int LIVE_UPDATE_CYC = (LIVE_UPDATE_US * (CLK_HZ / 1_000_000));

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LIVE_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_EVENT_HIGH  = 8'h10;
  localparam logic [7:0] OFS_EVENT_LOW   = 8'h11;
  localparam logic [7:0] OFS_MASK_HIGH   = 8'h12;
  localparam logic [7:0] OFS_MASK_LOW    = 8'h13;
  localparam logic [7:0] OFS_LIVE_HIGH   = 8'h14;
  localparam logic [7:0] OFS_LIVE_LOW    = 8'h15;
  localparam logic [7:0] OFS_DIGEST_DRV  = 8'h18;
  localparam logic [7:0] OFS_DIGEST_SAFE = 8'h36;

  // Reset values
  localparam logic [7:0]  RST_EVENT = 8'h00;
  localparam logic [7:0]  RST_MASK  = 8'h00;
  localparam logic [7:0]  RST_RDATA = 8'h00;
  localparam logic [15:0] RST_LIVE  = 16'h0000;

  // High event register fields
  localparam int EVH_FAST_POS  = 0;
  localparam int EVH_SAFE_CH1  = 1;
  localparam int EVH_SAFE_CH2  = 2;
  localparam int EVH_AGGREGATE = 3;
  localparam int EVH_CRIT_LSB  = 4;
  localparam int EVH_CRIT_W    = 4;

  // Low event register fields
  localparam int EVL_REPLY_INV = 0;
  localparam int EVL_WARN_LSB  = 1;
  localparam int EVL_WARN_W    = 7;

  // Error-group digest fields
  localparam int GRP_FAST_POS   = 0;
  localparam int GRP_SAFE_POS   = 1;
  localparam int GRP_INIT       = 2;
  localparam int GRP_MONITOR    = 3;
  localparam int GRP_RESOURCE   = 4;
  localparam int GRP_USER_WARN  = 7;
  localparam logic [7:0] GRP_VALID_MASK = 8'h9F;

  // Link frame bit counter
  localparam logic [4:0] LINK_CNT_IDLE = 5'h00;
  localparam logic [4:0] LINK_CNT_ONE  = 5'h01;
  localparam logic [4:0] LINK_CNT_MAX  = 5'h10;

  // Present conditions reported by the feedback system
  typedef struct packed {
    logic                  fastPosFault;
    logic                  safeAngleFaultCh1;
    logic                  safeAngleFaultCh2;
    logic [EVH_CRIT_W-1:0] critical;
    logic [EVL_WARN_W-1:0] warning;
    logic [7:0]            groupErr;
  } eesl_cond_s;

  // Register access request from one interface
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } eesl_req_s;

endpackage : eesl_pkg

// [hdl/eesl_sync.sv]
// Two-flop synchroniser for independent level signals.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none
module eesl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1_ff;

  initial begin
    if (W < 1) $error("eesl_sync: W must be at least 1");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_ff <= '0;
      dout      <= '0;
    end else begin
      stage1_ff <= din;
      dout      <= stage1_ff;
    end
  end
endmodule : eesl_sync
`default_nettype wire

// [hdl/eesl_status_xfer.sv]
// Toggle handshake moving the live status word into the link clock domain.
// Assumes the link clock may stop between frames; the word then waits held.
`timescale 1ns/1ps
`default_nettype none
module eesl_status_xfer
  import eesl_pkg::*;
#(
  parameter int W = LIVE_W
) (
  input  wire logic         refClk,
  input  wire logic         resetn,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] srcWord,
  input  wire logic         linkClk,
  output logic      [W-1:0] linkWord
);
  logic [W-1:0] hold_ff;
  logic         reqTgl_ff;
  logic         ackTgl_ff;
  logic         ackSeen;
  logic         reqSeen;
  wire          srcIdle   = (reqTgl_ff == ackSeen);
  wire          newArrive = (reqSeen != ackTgl_ff);

  initial begin
    if (W < 1) $error("eesl_status_xfer: W must be at least 1");
  end

  // Holding word is frozen while a request is outstanding
  always_ff @(posedge refClk or negedge resetn) begin
    if (!resetn) begin
      hold_ff   <= '0;
      reqTgl_ff <= 1'b0;
    end else if (clkEn && srcIdle) begin
      hold_ff   <= srcWord;
      reqTgl_ff <= ~reqTgl_ff;
    end
  end

  eesl_sync #(.W(1)) uReqSync (
    .clk    (linkClk),
    .resetn (resetn),
    .din    (reqTgl_ff),
    .dout   (reqSeen)
  );

  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      linkWord  <= '0;
      ackTgl_ff <= 1'b0;
    end else if (newArrive) begin
      linkWord  <= hold_ff;
      ackTgl_ff <= reqSeen;
    end
  end

  eesl_sync #(.W(1)) uAckSync (
    .clk    (refClk),
    .resetn (resetn),
    .din    (ackTgl_ff),
    .dout   (ackSeen)
  );
endmodule : eesl_status_xfer
`default_nettype wire

// [hdl/eesl_status_core.sv]
// Event and status reporting of the motor-feedback link master.
// Assumes condition inputs are levels from logic on refClk, the reply-invalid and
// message-reset inputs are one-cycle pulses on refClk, and the drive SPI link
// has its own clock that only runs while its chip select is low.
`timescale 1ns/1ps
`default_nettype none
module eesl_status_core
  import eesl_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  clkEn,
  input  wire eesl_pkg::eesl_cond_s  cond,
  input  wire logic                  replyInvalid,
  input  wire logic                  msgResetReq,
  input  wire eesl_pkg::eesl_req_s   drvReq,
  output logic [eesl_pkg::DATA_W-1:0] drvRdData,
  input  wire eesl_pkg::eesl_req_s   safeReq,
  output logic [eesl_pkg::DATA_W-1:0] safeRdData,
  output logic                       irq,
  output logic                       msgResetPulse,
  input  wire logic                  spiClk,
  input  wire logic                  spiCsN,
  output logic                       spiMiso
);
  import eesl_pkg::*;

  logic [7:0]        eventHigh_ff;
  logic [7:0]        eventLow_ff;
  logic [7:0]        maskHigh_ff;
  logic [7:0]        maskLow_ff;
  logic [7:0]        digest_ff;
  logic [LIVE_W-1:0] live_ff;
  logic [LIVE_W-1:0] linkSnap;
  logic [LIVE_W-1:0] shift_ff;
  logic [4:0]        bitCnt_ff;

  // Present conditions, packed into the same layout as the event registers
  wire logic [7:0] groupNow = cond.groupErr & GRP_VALID_MASK;
  wire logic       aggNow   = |groupNow;
  wire logic [7:0] condHigh = {cond.critical, aggNow, cond.safeAngleFaultCh2,
                               cond.safeAngleFaultCh1, cond.fastPosFault};
  wire logic [7:0] condLow  = {cond.warning, 1'b0};
  wire logic [7:0] setHigh  = condHigh;
  wire logic [7:0] setLow   = condLow | {7'h00, replyInvalid};

  // Drive port decode
  wire logic drvWrEvH   = drvReq.wr && (drvReq.addr == OFS_EVENT_HIGH);
  wire logic drvWrEvL   = drvReq.wr && (drvReq.addr == OFS_EVENT_LOW);
  wire logic drvWrMaskH = drvReq.wr && (drvReq.addr == OFS_MASK_HIGH);
  wire logic drvWrMaskL = drvReq.wr && (drvReq.addr == OFS_MASK_LOW);
  wire logic [7:0] clrHigh = drvWrEvH ? drvReq.wdata : 8'h00;
  wire logic [7:0] clrLow  = drvWrEvL ? drvReq.wdata : 8'h00;

  // Set wins over a clear in the same cycle; nothing else ever clears a bit
  wire logic [7:0] nxt_eventHigh = (eventHigh_ff & ~clrHigh) | setHigh;
  wire logic [7:0] nxt_eventLow  = (eventLow_ff & ~clrLow) | setLow;
  wire logic       nxt_irq = |(eventHigh_ff & maskHigh_ff) | |(eventLow_ff & maskLow_ff);

  // Live word follows present conditions plus the reply-invalid pulse
  wire logic [LIVE_W-1:0] nxt_live = {condHigh, condLow | {7'h00, replyInvalid}};

  logic [7:0] drvSel;
  always_comb begin
    case (drvReq.addr)
      OFS_EVENT_HIGH: drvSel = eventHigh_ff;
      OFS_EVENT_LOW:  drvSel = eventLow_ff;
      OFS_MASK_HIGH:  drvSel = maskHigh_ff;
      OFS_MASK_LOW:   drvSel = maskLow_ff;
      OFS_LIVE_HIGH:  drvSel = live_ff[15:8];
      OFS_LIVE_LOW:   drvSel = live_ff[7:0];
      OFS_DIGEST_DRV: drvSel = digest_ff;
      default:        drvSel = 8'h00;
    endcase
  end

  // The safe port reaches the digest and nothing else
  wire logic [7:0] safeSel = (safeReq.addr == OFS_DIGEST_SAFE) ? digest_ff : 8'h00;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eventHigh_ff <= RST_EVENT;
      eventLow_ff  <= RST_EVENT;
    end else if (clkEn) begin
      eventHigh_ff <= nxt_eventHigh;
      eventLow_ff  <= nxt_eventLow;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      maskHigh_ff <= RST_MASK;
      maskLow_ff  <= RST_MASK;
    end else if (clkEn) begin
      if (drvWrMaskH) maskHigh_ff <= drvReq.wdata;
      if (drvWrMaskL) maskLow_ff <= drvReq.wdata;
    end
  end

  // Digest mirrors group errors; software writes never reach it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      digest_ff <= RST_EVENT;
      live_ff   <= RST_LIVE;
    end else if (clkEn) begin
      digest_ff <= groupNow;
      live_ff   <= nxt_live;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      drvRdData  <= RST_RDATA;
      safeRdData <= RST_RDATA;
    end else if (clkEn) begin
      if (drvReq.rd) drvRdData <= drvSel;
      if (safeReq.rd) safeRdData <= safeSel;
    end
  end

  // Message reset only reaches the parameter channel; event, position and
  // live-status logic has no term from it, so position data runs on untouched
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq           <= 1'b0;
      msgResetPulse <= 1'b0;
    end else if (clkEn) begin
      irq           <= nxt_irq;
      msgResetPulse <= msgResetReq;
    end
  end

  // Live word crosses to the link clock by toggle handshake
  eesl_status_xfer #(.W(LIVE_W)) uXfer (
    .refClk   (ref_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .srcWord  (live_ff),
    .linkClk  (spiClk),
    .linkWord (linkSnap)
  );

  // Frame logic is cleared by chip select itself, since the link clock stops
  // between frames. MSB first, changed on rising edge for a falling-edge sampler.
  always_ff @(posedge spiClk or posedge spiCsN) begin
    if (spiCsN) begin
      bitCnt_ff <= LINK_CNT_IDLE;
      shift_ff  <= RST_LIVE;
      spiMiso   <= 1'b0;
    end else if (bitCnt_ff == LINK_CNT_IDLE) begin
      bitCnt_ff <= LINK_CNT_ONE;
      shift_ff  <= {linkSnap[LIVE_W-2:0], 1'b0};
      spiMiso   <= linkSnap[LIVE_W-1];
    end else begin
      bitCnt_ff <= (bitCnt_ff == LINK_CNT_MAX) ? LINK_CNT_MAX : bitCnt_ff + 5'h01;
      shift_ff  <= {shift_ff[LIVE_W-2:0], 1'b0};
      spiMiso   <= shift_ff[LIVE_W-1];
    end
  end

endmodule : eesl_status_core
`default_nettype wire

// [bench/eesl_status_properties.sv]
// Port-level checks of the event and status core.
// Assumes no read or message request while clkEn is low; bound into every core instance.
`timescale 1ns/1ps
`default_nettype none
module eesl_status_properties
  import eesl_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        resetn,
  input wire eesl_pkg::eesl_cond_s        cond,
  input wire logic                        msgResetReq,
  input wire eesl_pkg::eesl_req_s         drvReq,
  input wire logic [eesl_pkg::DATA_W-1:0] drvRdData,
  input wire eesl_pkg::eesl_req_s         safeReq,
  input wire logic [eesl_pkg::DATA_W-1:0] safeRdData,
  input wire logic                        irq,
  input wire logic                        msgResetPulse,
  input wire logic                        spiCsN,
  input wire logic                        spiMiso
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  safe_digest_a:
    assert property (safeReq.rd && safeReq.addr == 8'h36 && $stable(cond.groupErr) && $past(resetn)
      |=> safeRdData == ($past(cond.groupErr) & 8'h9F)) else $error("bad safe digest");
  safe_only_a:
    assert property (safeReq.rd && safeReq.addr != 8'h36 |=> safeRdData == 8'h00)
      else $error("safe port leaked data");
  drive_hides_a:
    assert property (drvReq.rd && drvReq.addr == 8'h36 |=> drvRdData == 8'h00)
      else $error("digest leaked to drive port");
  mirror_eq_a:
    assert property (drvReq.rd && drvReq.addr == 8'h18 && safeReq.rd && safeReq.addr == 8'h36
      |=> drvRdData == safeRdData) else $error("mirror differs");
  reserved_zero_a:
    assert property (drvReq.rd && drvReq.addr == 8'h18 |=> drvRdData[6:5] == 2'b00)
      else $error("reserved digest bits set");
  // Only a write can lower irq; events themselves never decay
  irq_sticky_a:
    assert property (irq && !$past(drvReq.wr) |=> irq) else $error("irq dropped alone");
  msg_pulse_a:
    assert property (msgResetReq |=> msgResetPulse ##1 !msgResetPulse)
      else $error("bad message reset pulse");
  miso_idle_a:
    assert property (spiCsN && $past(spiCsN) |-> !spiMiso) else $error("miso busy outside frame");
endmodule : eesl_status_properties

bind eesl_status_core eesl_status_properties u_props (
  .ref_clk(ref_clk), .resetn(resetn), .cond(cond), .msgResetReq(msgResetReq), .drvReq(drvReq),
  .drvRdData(drvRdData), .safeReq(safeReq), .safeRdData(safeRdData), .irq(irq),
  .msgResetPulse(msgResetPulse), .spiCsN(spiCsN), .spiMiso(spiMiso));
`default_nettype wire

// [bench/eesl_drive_master.sv]
// Drive-side SPI master model of the inverter application.
// Assumes the bench starts frames; the clock stands low between them.
`timescale 1ns/1ps
`default_nettype none
module eesl_drive_master (
  output logic      spiClk,
  output logic      spiCsN,
  input  wire logic spiMiso
);
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
  end
  // Samples on falling edges, MSB first
  task automatic xfer(output logic [15:0] word);
    #13 spiCsN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #32 spiClk = 1'b1;
      #32 spiClk = 1'b0;
      word[i] = spiMiso;
    end
    #32 spiCsN = 1'b1;
  endtask : xfer
endmodule : eesl_drive_master
`default_nettype wire

// [bench/eesl_status_core_tb.sv]
// Self-checking bench for the event and status core.
// Assumes the drive master model supplies link frames on demand.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module eesl_status_core_tb;
  import eesl_pkg::*;
  logic        ref_clk      = 1'b0;
  logic        resetn       = 1'b0;
  eesl_cond_s  cond         = '0;
  logic        replyInvalid = 1'b0;
  logic        msgResetReq  = 1'b0;
  logic        clkEn        = 1'b1;
  eesl_req_s   drvReq       = '0;
  eesl_req_s   safeReq      = '0;
  logic [7:0]  drvRdData, safeRdData;
  logic        irq, msgResetPulse, spiClk, spiCsN, spiMiso;
  logic [15:0] w;
  logic [7:0]  ofs [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18};
  int          errors = 0, total_checks = 0, cycles = 0;

  always #50 ref_clk = ~ref_clk;

  eesl_status_core dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .cond(cond),
    .replyInvalid(replyInvalid), .msgResetReq(msgResetReq), .drvReq(drvReq), .drvRdData(drvRdData),
    .safeReq(safeReq), .safeRdData(safeRdData), .irq(irq), .msgResetPulse(msgResetPulse),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiMiso(spiMiso));
  eesl_drive_master pm (.spiClk(spiClk), .spiCsN(spiCsN), .spiMiso(spiMiso));

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    drvReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    drvReq.wr <= 1'b0;
  endtask : wr

  // Drive and safe reads go out together so the mirror can be compared
  task automatic rd(input logic [7:0] a, s, ed, es);
    @(posedge ref_clk);
    drvReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    safeReq <= '{rd: 1'b1, wr: 1'b0, addr: s, wdata: 8'h00};
    @(posedge ref_clk);
    drvReq.rd <= 1'b0;
    safeReq.rd <= 1'b0;
    tick(1);
    `CHK("drvRdData", drvRdData, ed)
    `CHK("safeRdData", safeRdData, es)
  endtask : rd

  // First frame after a change may still carry the old word
  task automatic live(input logic [15:0] e);
    pm.xfer(w);
    tick(4);
    pm.xfer(w);
    tick(4);
    `CHK("live", w, e)
  endtask : live

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h36, 8'h00, 8'h00);
    $display("test reset done");
    @(posedge ref_clk);
    cond <= {3'b101, 4'hA, 7'h55, 8'hFF};
    tick(3);
    rd(8'h10, 8'h36, 8'hAD, 8'h9F);
    rd(8'h11, 8'h18, 8'hAA, 8'h00);
    rd(8'h18, 8'h36, 8'h9F, 8'h9F);
    rd(8'h36, 8'h10, 8'h00, 8'h00);
    live(16'hADAA);
    @(posedge ref_clk);
    cond <= '0;
    tick(3);
    rd(8'h10, 8'h36, 8'hAD, 8'h00);
    live(16'h0000);
    $display("test latch done");
    wr(8'h10, 8'h01);
    rd(8'h10, 8'h36, 8'hAC, 8'h00);
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'hFF);
    wr(8'h18, 8'hFF);
    rd(8'h10, 8'h11, 8'h00, 8'h00);
    rd(8'h18, 8'h36, 8'h00, 8'h00);
    $display("test clear done");
    @(posedge ref_clk);
    cond <= {3'b010, 19'h00000};
    @(posedge ref_clk);
    cond <= '0;
    tick(3);
    `CHK("irq", irq, 1'b0)
    wr(8'h12, 8'h02);
    tick(2);
    `CHK("irq", irq, 1'b1)
    rd(8'h12, 8'h36, 8'h02, 8'h00);
    wr(8'h12, 8'h00);
    tick(2);
    `CHK("irq", irq, 1'b0)
    wr(8'h12, 8'hFF);
    wr(8'h10, 8'h02);
    tick(2);
    `CHK("irq", irq, 1'b0)
    $display("test irq done");
    @(posedge ref_clk);
    replyInvalid <= 1'b1;
    msgResetReq <= 1'b1;
    @(posedge ref_clk);
    replyInvalid <= 1'b0;
    msgResetReq <= 1'b0;
    #1;
    `CHK("msgResetPulse", msgResetPulse, 1'b1)
    rd(8'h11, 8'h36, 8'h01, 8'h00);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h36, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      cond.groupErr <= 8'h01 << i;
      tick(2);
      rd(8'h18, 8'h36, (8'h01 << i) & 8'h9F, (8'h01 << i) & 8'h9F);
    end
    rd(8'h10, 8'h36, 8'h08, 8'h80);
    $display("test digest done");
    // With the clock enable low, a fault pulse and a mask write must both be lost
    @(posedge ref_clk);
    clkEn <= 1'b0;
    cond.fastPosFault <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cond.fastPosFault <= 1'b0;
    wr(8'h12, 8'h00);
    clkEn <= 1'b1;
    tick(2);
    `CHK("irq", irq, 1'b1)
    rd(8'h10, 8'h36, 8'h08, 8'h80);
    rd(8'h12, 8'h36, 8'hFF, 8'h80);
    $display("test clock enable done");
    summarize();
  end
endmodule : eesl_status_core_tb
`default_nettype wire
